/* File: sleep_gate_pkg.sv */
// Shared constants and types for the sleep-time power gating block.
// Assumes a single 100 MHz clock domain and an 8-bit register port.
package sleep_gate_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam int          NUM_PINS        = 16;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          VREF_STARTUP_NS = 1000;
    localparam int          VREF_CNT_W      = 16;
    localparam int          VREF_STARTUP_CYCLES =
        (VREF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0]  CTRL_ADDR       = 4'h0;
    localparam logic [3:0]  DIS0_ADDR       = 4'h1;
    localparam logic [3:0]  DIS1_ADDR       = 4'h2;
    localparam logic [3:0]  WAKE0_ADDR      = 4'h3;
    localparam logic [3:0]  WAKE1_ADDR      = 4'h4;
    localparam logic [3:0]  STATUS_ADDR     = 4'h5;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int          CTRL_ADC_BIT    = 0;
    localparam int          CTRL_COMP_BIT   = 1;
    localparam int          CTRL_CREF_BIT   = 2;
    localparam int          CTRL_WDT_BIT    = 3;
    localparam int          CTRL_MODE_LSB   = 4;
    localparam int          CTRL_GO_BIT     = 7;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int          STAT_SLEEP_BIT  = 0;
    localparam int          STAT_ADC_BIT    = 1;
    localparam int          STAT_COMP_BIT   = 2;
    localparam int          STAT_VREF_BIT   = 3;
    localparam int          STAT_RDY_BIT    = 4;
    localparam int          STAT_BOD_BIT    = 5;
    localparam int          STAT_EXT_BIT    = 6;
    localparam int          STAT_MCLK_BIT   = 7;

    // ------------------------------------------------------------
    // Sleep mode codes and fuse values
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_IDLE       = 3'h0;
    localparam logic [2:0]  MODE_ADC_NR     = 3'h1;
    localparam logic [2:0]  MODE_PDOWN      = 3'h2;
    localparam logic [2:0]  MODE_PSAVE      = 3'h3;
    localparam logic [2:0]  MODE_STANDBY    = 3'h6;
    localparam logic [2:0]  MODE_EXT_STBY   = 3'h7;
    localparam logic [2:0]  BOD_FUSE_OFF    = 3'h7;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;

    typedef enum logic [1:0] {
        PWR_ACTIVE   = 2'b01,
        PWR_SLEEPING = 2'b10
    } power_state_type;

    typedef struct packed {
        logic cpu;
        logic io;
        logic adc;
        logic main;
    } clock_gates_type;

endpackage

/* File: pin_gate_if.sv */
// Carries per-pin masks and the gated input enables between the
// gating core and the pin input gate. Single clock domain assumed.
interface pin_gate_if #(parameter int PINS = 16);
    logic [PINS-1:0] disable_mask;
    logic [PINS-1:0] wake_mask;
    logic            buffers_off;
    logic [PINS-1:0] input_enable;

    modport core (output disable_mask, output wake_mask, output buffers_off,
                  input input_enable);
    modport gate (input disable_mask, input wake_mask, input buffers_off,
                  output input_enable);
endinterface

/* File: pin_input_gate.sv */
// Per-pin digital input buffer enables.
// Assumes masks and the buffer shutdown request arrive on clk.
module pin_input_gate #(
    parameter int PINS = 16
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Gating core
    pin_gate_if.gate  pg
);
    import sleep_gate_pkg::*;

    typedef struct packed {
        logic [PINS-1:0] en;
    } gate_state_type;

    gate_state_type r_reg;
    gate_state_type r_next;

    // ------------------------------------------------------------
    // Enable per pin
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        for (int i = 0; i < PINS; i++) begin
            // Software disable overrides even wake pins
            r_next.en[i] = !pg.disable_mask[i] &&
                           (!pg.buffers_off ||
                            pg.wake_mask[i]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pg.input_enable = r_reg.en;
endmodule

/* File: sleep_power_gating.sv */
// Sleep-time power gating: decides which functions keep running or
// clocked while the core sleeps. Assumes fuses and wake event come
// from pins (synchronised here) and conv_start from logic on clk.
//
// The placing of the registers and the strobed register port were left to the implementer.
module sleep_power_gating
    import sleep_gate_pkg::*;
#(
    parameter int PINS         = NUM_PINS,
    parameter int VREF_CYCLES  = VREF_STARTUP_CYCLES
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Register port
    input  wire logic [sleep_gate_pkg::ADDR_W-1:0] addr,
    input  wire logic [sleep_gate_pkg::DATA_W-1:0] wdata,
    input  wire logic                         wr_strobe,
    input  wire logic                         rd_strobe,
    output logic      [sleep_gate_pkg::DATA_W-1:0] rdata,
    // Fuses and wake source
    input  wire logic [2:0]                   brownout_level_fuses,
    input  wire logic                         debug_enable_fuse,
    input  wire logic                         wake_event,
    // Converter handshake
    input  wire logic                         conv_start,
    output logic                              adc_extended,
    // Run enables
    output logic                              adc_run,
    output logic                              comp_run,
    output logic                              vref_on,
    output logic                              vref_ready,
    output logic                              brownout_detector_run,
    output logic                              wdt_run,
    // Clock enables
    output logic                              cpu_clk_en,
    output logic                              io_clk_en,
    output logic                              adc_clk_en,
    output logic                              main_clk_en,
    // Pin input enables
    output logic      [PINS-1:0]              pin_input_en
);
    import sleep_gate_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        power_state_type         pstate;
        logic [2:0]              mode;
        logic                    adc_en;
        logic                    comp_en;
        logic                    comp_ref;
        logic                    wdt_en;
        logic [7:0]              dis0;
        logic [7:0]              dis1;
        logic [7:0]              wake0;
        logic [7:0]              wake1;
        logic [DATA_W-1:0]       rdata;
        logic [3:0]              fuse_meta;
        logic [3:0]              fuse_sync;
        logic                    wake_meta;
        logic                    wake_sync;
        logic                    ext_pending;
        logic [VREF_CNT_W-1:0]   vref_cnt;
        logic                    vref_ready;
        logic                    adc_run;
        logic                    comp_run;
        logic                    vref_on;
        logic                    bod_run;
        logic                    wdt_run;
        clock_gates_type         clocks;
        logic                    buffers_off;
    } gate_core_type;

    gate_core_type r_reg;
    gate_core_type r_next;

    localparam logic [VREF_CNT_W-1:0] VREF_LIMIT = VREF_CNT_W'(VREF_CYCLES);

    pin_gate_if #(.PINS(PINS)) pg ();

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Unknown mode codes fall back to the deepest gating
    function automatic clock_gates_type mode_clocks(
        input logic       sleeping,
        input logic [2:0] mode,
        input logic       debug_fuse
    );
        clock_gates_type g;
        g.cpu  = !sleeping;
        g.io   = !sleeping || (mode == MODE_IDLE);
        g.adc  = !sleeping || (mode == MODE_IDLE) || (mode == MODE_ADC_NR);
        g.main = !sleeping || debug_fuse ||
                 (mode == MODE_IDLE) || (mode == MODE_ADC_NR) ||
                 (mode == MODE_STANDBY) || (mode == MODE_EXT_STBY);
        return g;
    endfunction

    function automatic logic comp_allowed(
        input logic       sleeping,
        input logic [2:0] mode
    );
        return !sleeping || (mode == MODE_IDLE) || (mode == MODE_ADC_NR);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic sleeping;
        logic bus_go;
        sleeping = 1'b0;
        bus_go   = 1'b0;
        r_next   = r_reg;

        // Pin inputs pass two flops before use
        r_next.fuse_meta = {debug_enable_fuse, brownout_level_fuses};
        r_next.fuse_sync = r_reg.fuse_meta;
        r_next.wake_meta = wake_event;
        r_next.wake_sync = r_reg.wake_meta;

        // Register writes
        if (wr_strobe) begin
            case (addr)
                CTRL_ADDR: begin
                    r_next.adc_en   = wdata[CTRL_ADC_BIT];
                    r_next.comp_en  = wdata[CTRL_COMP_BIT];
                    r_next.comp_ref = wdata[CTRL_CREF_BIT];
                    r_next.wdt_en   = wdata[CTRL_WDT_BIT];
                    if (r_reg.pstate == PWR_ACTIVE) begin
                        r_next.mode = wdata[CTRL_MODE_LSB +: 3];
                    end
                    bus_go = wdata[CTRL_GO_BIT];
                end
                DIS0_ADDR:  r_next.dis0  = wdata;
                DIS1_ADDR:  r_next.dis1  = wdata;
                WAKE0_ADDR: r_next.wake0 = wdata;
                WAKE1_ADDR: r_next.wake1 = wdata;
                default: begin
                end
            endcase
        end

        // Sleep entry and wake
        case (r_reg.pstate)
            PWR_ACTIVE: begin
                if (bus_go) begin
                    r_next.pstate = PWR_SLEEPING;
                end
            end
            PWR_SLEEPING: begin
                if (r_reg.wake_sync) begin
                    r_next.pstate = PWR_ACTIVE;
                end
            end
            default: begin
                r_next.pstate = PWR_ACTIVE;
            end
        endcase

        // Run enables follow the state being entered
        sleeping         = (r_next.pstate == PWR_SLEEPING);
        r_next.clocks    = mode_clocks(sleeping, r_next.mode, r_reg.fuse_sync[3]);
        r_next.adc_run   = r_next.adc_en;
        r_next.comp_run  = r_next.comp_en &&
                           comp_allowed(sleeping, r_next.mode);
        r_next.bod_run   = (r_reg.fuse_sync[2:0] != BOD_FUSE_OFF);
        r_next.wdt_run   = r_next.wdt_en;
        r_next.vref_on   = r_next.bod_run || r_next.adc_run ||
                           r_next.comp_run ||
                           (r_next.comp_en && r_next.comp_ref);
        r_next.buffers_off = !r_next.clocks.io && !r_next.clocks.adc;

        // Extended conversion after re-enable; set beats clear
        if (r_next.adc_run && !r_reg.adc_run) begin
            r_next.ext_pending = 1'b1;
        end else if (conv_start) begin
            r_next.ext_pending = 1'b0;
        end

        // Reference start-up; stays ready while kept on
        if (!r_next.vref_on) begin
            r_next.vref_cnt   = '0;
            r_next.vref_ready = 1'b0;
        end else if (r_reg.vref_cnt < VREF_LIMIT) begin
            r_next.vref_cnt   = r_reg.vref_cnt + 1'b1;
            r_next.vref_ready = 1'b0;
        end else begin
            r_next.vref_ready = 1'b1;
        end

        // Read data, valid the cycle after the strobe only
        r_next.rdata = BYTE_ZERO;
        if (rd_strobe) begin
            case (addr)
                CTRL_ADDR: begin
                    r_next.rdata[CTRL_ADC_BIT]         = r_reg.adc_en;
                    r_next.rdata[CTRL_COMP_BIT]        = r_reg.comp_en;
                    r_next.rdata[CTRL_CREF_BIT]        = r_reg.comp_ref;
                    r_next.rdata[CTRL_WDT_BIT]         = r_reg.wdt_en;
                    r_next.rdata[CTRL_MODE_LSB +: 3]   = r_reg.mode;
                end
                DIS0_ADDR:   r_next.rdata = r_reg.dis0;
                DIS1_ADDR:   r_next.rdata = r_reg.dis1;
                WAKE0_ADDR:  r_next.rdata = r_reg.wake0;
                WAKE1_ADDR:  r_next.rdata = r_reg.wake1;
                STATUS_ADDR: begin
                    r_next.rdata[STAT_SLEEP_BIT] = (r_reg.pstate == PWR_SLEEPING);
                    r_next.rdata[STAT_ADC_BIT]   = r_reg.adc_run;
                    r_next.rdata[STAT_COMP_BIT]  = r_reg.comp_run;
                    r_next.rdata[STAT_VREF_BIT]  = r_reg.vref_on;
                    r_next.rdata[STAT_RDY_BIT]   = r_reg.vref_ready;
                    r_next.rdata[STAT_BOD_BIT]   = r_reg.bod_run;
                    r_next.rdata[STAT_EXT_BIT]   = r_reg.ext_pending;
                    r_next.rdata[STAT_MCLK_BIT]  = r_reg.clocks.main;
                end
                default: begin
                    r_next.rdata = BYTE_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset leaves the core running with everything optional off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg        <= '0;
            r_reg.pstate <= PWR_ACTIVE;
            // Sync idles at detector-off, so no false run follows reset
            r_reg.fuse_meta <= {1'b0, BOD_FUSE_OFF};
            r_reg.fuse_sync <= {1'b0, BOD_FUSE_OFF};
            r_reg.clocks <= '{cpu: 1'b1, io: 1'b1, adc: 1'b1, main: 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Pin gating
    // ------------------------------------------------------------
    assign pg.disable_mask = PINS'({r_reg.dis1, r_reg.dis0});
    assign pg.wake_mask    = PINS'({r_reg.wake1, r_reg.wake0});
    assign pg.buffers_off  = r_reg.buffers_off;

    pin_input_gate #(.PINS(PINS)) u_pin_gate (
        .clk   (clk),
        .rst_n (rst_n),
        .pg    (pg)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata                 = r_reg.rdata;
    assign adc_extended          = r_reg.ext_pending;
    assign adc_run               = r_reg.adc_run;
    assign comp_run              = r_reg.comp_run;
    assign vref_on               = r_reg.vref_on;
    assign vref_ready            = r_reg.vref_ready;
    assign brownout_detector_run = r_reg.bod_run;
    assign wdt_run               = r_reg.wdt_run;
    assign cpu_clk_en            = r_reg.clocks.cpu;
    assign io_clk_en             = r_reg.clocks.io;
    assign adc_clk_en            = r_reg.clocks.adc;
    assign main_clk_en           = r_reg.clocks.main;
    assign pin_input_en          = pg.input_enable;
endmodule

/* File: sleep_power_gating_checker.sv */
// Concurrent checks on the sleep gating block's top-level ports.
// Assumes one clock, async active-low reset, bound from the bench.
module sleep_power_gating_checker #(
    parameter int VREF_CYCLES = 4
) (
    // Clock and reset
    input wire logic                               clk,
    input wire logic                               rst_n,
    // Register port
    input wire logic [sleep_gate_pkg::ADDR_W-1:0]  addr,
    input wire logic [sleep_gate_pkg::DATA_W-1:0]  wdata,
    input wire logic                               wr_strobe,
    input wire logic                               rd_strobe,
    input wire logic [sleep_gate_pkg::DATA_W-1:0]  rdata,
    // Fuses, wake and converter
    input wire logic [2:0]                         brownout_level_fuses,
    input wire logic                               debug_enable_fuse,
    input wire logic                               wake_event,
    input wire logic                               conv_start,
    input wire logic                               adc_extended,
    // Run and clock enables
    input wire logic                               adc_run,
    input wire logic                               comp_run,
    input wire logic                               vref_on,
    input wire logic                               vref_ready,
    input wire logic                               brownout_detector_run,
    input wire logic                               wdt_run,
    input wire logic                               cpu_clk_en,
    input wire logic                               adc_clk_en,
    input wire logic                               main_clk_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import sleep_gate_pkg::*;

    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Fuse history mirrors the two-flop sync plus the output flop
    logic [15:0] vref_cnt_reg;
    logic [2:0]  settle_reg;
    logic [2:0]  fuse_d1_reg;
    logic [2:0]  fuse_d2_reg;
    logic [2:0]  fuse_d3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vref_cnt_reg <= 16'h0000;
            settle_reg   <= 3'h0;
            fuse_d1_reg  <= 3'h7;
            fuse_d2_reg  <= 3'h7;
            fuse_d3_reg  <= 3'h7;
        end else begin
            vref_cnt_reg <= !vref_on ? 16'h0000 :
                            (vref_cnt_reg == 16'hFFFF ? vref_cnt_reg : vref_cnt_reg + 16'h0001);
            settle_reg   <= (settle_reg == 3'h7) ? settle_reg : settle_reg + 3'h1;
            fuse_d1_reg  <= brownout_level_fuses;
            fuse_d2_reg  <= fuse_d1_reg;
            fuse_d3_reg  <= fuse_d2_reg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    adc_stop_cause_a: assert property ($fell(adc_run) |-> $past(wr_strobe) &&
        $past(addr) == CTRL_ADDR && !$past(wdata[CTRL_ADC_BIT]))
        else $error("converter run dropped without a control write");
    ext_on_rise_a: assert property ($rose(adc_run) |-> adc_extended)
        else $error("extended flag not set on converter re-enable");
    ext_clear_a: assert property ((conv_start ##1 !$rose(adc_run)) |-> !adc_extended)
        else $error("extended flag not cleared by conversion start");
    comp_deep_off_a: assert property (!cpu_clk_en && !adc_clk_en |-> !comp_run)
        else $error("comparator running in deep sleep");
    vref_need_a: assert property (adc_run || comp_run |-> vref_on)
        else $error("reference off while a user runs");
    ref_early_a: assert property (vref_on && int'(vref_cnt_reg) < VREF_CYCLES |-> !vref_ready)
        else $error("reference ready before startup elapsed");
    ref_late_a: assert property (vref_on && int'(vref_cnt_reg) >= VREF_CYCLES |-> vref_ready)
        else $error("reference not ready after startup");
    bod_follow_a: assert property (settle_reg >= 3'h3 |->
        brownout_detector_run == (fuse_d3_reg != BOD_FUSE_OFF))
        else $error("detector run does not follow fuses");
    wdt_stop_cause_a: assert property ($fell(wdt_run) |-> $past(wr_strobe) &&
        $past(addr) == CTRL_ADDR && !$past(wdata[CTRL_WDT_BIT]))
        else $error("watchdog stopped without a control write");
    debug_main_a: assert property (debug_enable_fuse && $past(debug_enable_fuse, 3)
        |-> main_clk_en)
        else $error("main clock stopped with debug fuse set");
    sleep_entry_a: assert property (wr_strobe && addr == CTRL_ADDR &&
        wdata[CTRL_GO_BIT] && cpu_clk_en |-> ##1 !cpu_clk_en)
        else $error("go write did not stop the core clock");
    wake_bound_a: assert property ($rose(wake_event) && !cpu_clk_en |-> ##[1:6] cpu_clk_en)
        else $error("core clock not restored after wake");
    rdata_idle_a: assert property (!$past(rd_strobe) |-> rdata == 8'h00)
        else $error("read data not zero outside read cycle");
endmodule

/* File: testbench.sv */
// Directed bench for the sleep gating block over its register port.
// Assumes the checker module is compiled alongside and bound below.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sleep_gate_pkg::*;

    localparam int VC = 4;
    logic clk = 1'b0, rst_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [2:0] fuses = 3'h7;
    logic debug_fuse = 1'b0, wake_event = 1'b0, conv_start = 1'b0;
    logic adc_extended, adc_run, comp_run, vref_on, vref_ready, bod_run, wdt_run;
    logic cpu_clk_en, io_clk_en, adc_clk_en, main_clk_en;
    logic [15:0] pin_input_en;
    int n_errors = 0, num_checks = 0, cycles = 0;
    logic [2:0] modes [6] = '{MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE,
                              MODE_STANDBY, MODE_EXT_STBY};

    always #5 clk = ~clk;

    sleep_power_gating #(.VREF_CYCLES(VC)) sleep_power_gating_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .brownout_level_fuses(fuses),
        .debug_enable_fuse(debug_fuse), .wake_event(wake_event), .conv_start(conv_start),
        .adc_extended(adc_extended), .adc_run(adc_run), .comp_run(comp_run),
        .vref_on(vref_on), .vref_ready(vref_ready), .brownout_detector_run(bod_run),
        .wdt_run(wdt_run), .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en),
        .adc_clk_en(adc_clk_en), .main_clk_en(main_clk_en), .pin_input_en(pin_input_en));

    // ------------------------------------------------------------
    // Access and check tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    // Wake is a level; hold it until the core clock returns
    task automatic wake_up;
        int i;
        @(posedge clk);
        wake_event <= 1'b1;
        for (i = 0; i < 10 && cpu_clk_en !== 1'b1; i++)
            tick();
        @(posedge clk);
        wake_event <= 1'b0;
        #1;
        chk("cpu_clk_en", cpu_clk_en, 1'b1);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic io_e, adc_e;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("pin_input_en", pin_input_en, 16'hFFFF);
        chk("adc_run", adc_run, 1'b0);
        rd(STATUS_ADDR, 8'h80);
        rd(4'hF, 8'h00);
        $display("test reset done");
        wr(DIS0_ADDR, 8'h0F);
        wr(DIS1_ADDR, 8'h80);
        tick();
        chk("pin_input_en", pin_input_en, 16'h7FF0);
        rd(DIS1_ADDR, 8'h80);
        $display("test input disable done");
        wr(CTRL_ADDR, 8'h01);
        chk("adc_extended", adc_extended, 1'b1);
        chk("vref_on", vref_on, 1'b1);
        rd(STATUS_ADDR, 8'hCA);
        @(posedge clk);
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
        #1;
        chk("adc_extended", adc_extended, 1'b0);
        repeat (VC) tick();
        rd(STATUS_ADDR, 8'h9A);
        wr(CTRL_ADDR, 8'h00);
        chk("vref_on", vref_on, 1'b0);
        wr(CTRL_ADDR, 8'h01);
        chk("adc_extended", adc_extended, 1'b1);
        $display("test converter done");
        wr(DIS0_ADDR, 8'h01);
        wr(DIS1_ADDR, 8'h00);
        wr(WAKE0_ADDR, 8'h03);
        wr(WAKE1_ADDR, 8'h80);
        foreach (modes[j]) begin
            io_e = (modes[j] == MODE_IDLE);
            adc_e = io_e || modes[j] == MODE_ADC_NR;
            wr(CTRL_ADDR, {1'b1, modes[j], 4'hB});
            chk("io_clk_en", io_clk_en, io_e);
            chk("adc_clk_en", adc_clk_en, adc_e);
            chk("main_clk_en", main_clk_en, modes[j] != MODE_PDOWN && modes[j] != MODE_PSAVE);
            chk("comp_run", comp_run, adc_e);
            chk("adc_run", adc_run, 1'b1);
            chk("wdt_run", wdt_run, 1'b1);
            tick();
            chk("pin_input_en", pin_input_en, (io_e || adc_e) ? 16'hFFFE : 16'h8002);
            wake_up();
            chk("pin_input_en", pin_input_en, 16'hFFFE);
        end
        $display("test sleep modes done");
        wr(CTRL_ADDR, 8'h00);
        chk("wdt_run", wdt_run, 1'b0);
        @(posedge clk);
        debug_fuse <= 1'b1;
        repeat (4) tick();
        wr(CTRL_ADDR, {1'b1, MODE_PDOWN, 4'h6});
        chk("comp_run", comp_run, 1'b0);
        chk("vref_on", vref_on, 1'b1);
        chk("main_clk_en", main_clk_en, 1'b1);
        wake_up();
        @(posedge clk);
        debug_fuse <= 1'b0;
        $display("test reference and debug done");
        wr(CTRL_ADDR, 8'h00);
        @(posedge clk);
        fuses <= 3'h6;
        repeat (4) tick();
        chk("vref_on", vref_on, 1'b1);
        wr(CTRL_ADDR, {1'b1, MODE_PSAVE, 4'h0});
        tick();
        chk("bod_run", bod_run, 1'b1);
        chk("wdt_run", wdt_run, 1'b0);
        wake_up();
        $display("test brownout done");
        test_done();
    end
endmodule

bind sleep_power_gating sleep_power_gating_checker #(.VREF_CYCLES(VREF_CYCLES)) checker_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .brownout_level_fuses(brownout_level_fuses),
    .debug_enable_fuse(debug_enable_fuse), .wake_event(wake_event),
    .conv_start(conv_start), .adc_extended(adc_extended), .adc_run(adc_run),
    .comp_run(comp_run), .vref_on(vref_on), .vref_ready(vref_ready),
    .brownout_detector_run(brownout_detector_run), .wdt_run(wdt_run),
    .cpu_clk_en(cpu_clk_en), .adc_clk_en(adc_clk_en), .main_clk_en(main_clk_en));
